//--- inc/nvac_params.svh
// constants of the byte-wide non-volatile store access block
`ifndef NVAC_PARAMS_SVH
`define NVAC_PARAMS_SVH

// ----------------------------------------
// store geometry
// ----------------------------------------
`define NVAC_DEPTH 32
`define NVAC_AW 5
`define NVAC_DW 8
`define NVAC_BUS_AW 8

// ----------------------------------------
// register locations
// ----------------------------------------
`define NVAC_BANKSEL_OFS 8'h04
`define NVAC_ADDR_OFS 8'h2c
`define NVAC_DATA_OFS 8'h2d
`define NVAC_CTRL_OFS 8'h40
`define NVAC_CTRL_BANK 1'b1
`define NVAC_DIRECT_BANK 1'b0

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define NVAC_PE_BIT 3
`define NVAC_PT_BIT 2
`define NVAC_FE_BIT 1
`define NVAC_FT_BIT 0
`define NVAC_BANK_BIT 0
`define NVAC_RST_BYTE 8'h00
`define NVAC_UNMAPPED 8'h00

// ----------------------------------------
// timing
// ----------------------------------------
`define NVAC_TW 16
`define NVAC_WRITE_TICKS 16'h0040
`define NVAC_CW 2
`define NVAC_READ_CYCLES 2'h2

`endif

//--- inc/nvac_pkg.sv
// types of the byte-wide non-volatile store access block
`include "nvac_params.svh"

package nvac_pkg;

	typedef enum logic [1:0] {
		NVAC_IDLE,
		NVAC_READ,
		NVAC_WRITE
	} nvac_state_type;

	typedef struct packed {
		logic [`NVAC_AW-1:0] addr;
		logic [`NVAC_DW-1:0] data;
		logic program_enable;
		logic program_trigger;
		logic fetch_enable;
		logic fetch_trigger;
		logic bank_select_bit;
		nvac_state_type state;
		logic [`NVAC_CW-1:0] rd_cnt;
		logic nv_irq_flag;
		logic gie_clear;
		logic [`NVAC_DW-1:0] rdata;
	} nvac_regs_type;

	typedef struct packed {
		logic busy;
		logic slow_prev;
		logic [`NVAC_TW-1:0] ticks;
	} nvac_timer_type;

endpackage : nvac_pkg

//--- core/nvac_write_timer.sv
// write cycle timer paced by the low-speed clock
`timescale 1ns/1ps
`include "nvac_params.svh"

module nvac_write_timer
	import nvac_pkg::*;
(
	// clock and reset
	input wire logic i_clk,
	input wire logic i_srst,
	// control
	input wire logic i_start,
	input wire logic i_slow_clk,
	// status
	output logic o_busy,
	output logic o_done
);

	nvac_timer_type r;
	nvac_timer_type next_r;
	logic slow_rise;

	// ----------------------------------------
	// tick counting
	// ----------------------------------------
	always_comb begin
		next_r = r;
		slow_rise = i_slow_clk & ~r.slow_prev;
		o_done = 1'b0;
		next_r.slow_prev = i_slow_clk;
		if (i_start) begin
			next_r.busy = 1'b1;
			next_r.ticks = '0;
		end else if (r.busy && slow_rise) begin
			if (r.ticks == `NVAC_WRITE_TICKS - 16'h0001) begin
				next_r.busy = 1'b0;
				o_done = 1'b1;
			end else begin
				next_r.ticks = r.ticks + 16'h0001;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign o_busy = r.busy;

endmodule : nvac_write_timer

//--- core/nvac_top.sv
// byte-wide non-volatile store with its special function registers
`timescale 1ns/1ps
`include "nvac_params.svh"

module nvac_top
	import nvac_pkg::*;
(
	// clock and reset
	input wire logic i_clk,
	input wire logic i_srst,
	// data memory access from the core
	input wire logic [`NVAC_BUS_AW-1:0] i_bus_addr,
	input wire logic i_bus_indirect,
	input wire logic i_bus_wr,
	input wire logic i_bus_rd,
	input wire logic [`NVAC_DW-1:0] i_bus_wdata,
	output logic [`NVAC_DW-1:0] o_bus_rdata,
	// low-speed clock, sampled
	input wire logic i_slow_clk,
	// interrupt controller side
	input wire logic i_nv_irq_enable,
	input wire logic i_global_irq_enable,
	input wire logic i_stack_full,
	input wire logic i_irq_serviced,
	output logic o_nv_irq_flag,
	output logic o_irq_request,
	output logic o_global_irq_clear,
	// status
	output logic o_busy
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	nvac_regs_type r;
	nvac_regs_type next_r;
	logic [`NVAC_DW-1:0] store [0:`NVAC_DEPTH-1];
	logic eff_bank;
	logic hit_addr;
	logic hit_data;
	logic hit_bank;
	logic hit_ctrl;
	logic want_write;
	logic want_read;
	logic start_write;
	logic write_done;
	logic timer_busy;
	logic commit;
	logic [`NVAC_DW-1:0] ctrl_view;
	logic [`NVAC_DW-1:0] read_view;
	logic [`NVAC_DW-1:0] store_rdata;
	logic ctrl_wr;
	logic wr_pe;
	logic wr_pt;
	logic wr_fe;
	logic wr_ft;
	logic op_idle;
	logic both_trig;
	logic pt_allowed;
	logic ft_allowed;
	logic read_last;
	logic svc_hit;
	logic irq_gate;
	logic op_active;

	// ----------------------------------------
	// bank selection
	// ----------------------------------------
	// direct access always bank 0
	assign eff_bank = i_bus_indirect ? r.bank_select_bit : `NVAC_DIRECT_BANK;

	// ----------------------------------------
	// address decode
	// ----------------------------------------
	always_comb begin
		hit_addr = 1'b0;
		hit_data = 1'b0;
		hit_bank = 1'b0;
		hit_ctrl = 1'b0;
		if (eff_bank == `NVAC_CTRL_BANK && i_bus_addr == `NVAC_CTRL_OFS) begin
			hit_ctrl = 1'b1;
		end else if (eff_bank == `NVAC_DIRECT_BANK && i_bus_addr == `NVAC_ADDR_OFS) begin
			hit_addr = 1'b1;
		end else if (eff_bank == `NVAC_DIRECT_BANK && i_bus_addr == `NVAC_DATA_OFS) begin
			hit_data = 1'b1;
		end else if (i_bus_addr == `NVAC_BANKSEL_OFS) begin
			hit_bank = 1'b1;
		end
	end

	always_comb begin
		ctrl_view = `NVAC_RST_BYTE;
		ctrl_view[`NVAC_PE_BIT] = r.program_enable;
		ctrl_view[`NVAC_PT_BIT] = r.program_trigger;
		ctrl_view[`NVAC_FE_BIT] = r.fetch_enable;
		ctrl_view[`NVAC_FT_BIT] = r.fetch_trigger;
	end

	// ----------------------------------------
	// register read view
	// ----------------------------------------
	always_comb begin
		if (hit_ctrl) begin
			read_view = ctrl_view;
		end else if (hit_addr) begin
			read_view = {3'h0, r.addr};
		end else if (hit_data) begin
			read_view = r.data;
		end else if (hit_bank) begin
			read_view = {7'h00, r.bank_select_bit};
		end else begin
			read_view = `NVAC_UNMAPPED;
		end
	end

	// ----------------------------------------
	// control write fields
	// ----------------------------------------
	always_comb begin
		ctrl_wr = i_bus_wr & hit_ctrl;
		wr_pe = i_bus_wdata[`NVAC_PE_BIT];
		wr_pt = i_bus_wdata[`NVAC_PT_BIT];
		wr_fe = i_bus_wdata[`NVAC_FE_BIT];
		wr_ft = i_bus_wdata[`NVAC_FT_BIT];
	end

	// ----------------------------------------
	// refusal conditions
	// ----------------------------------------
	always_comb begin
		// triggers ignored while an operation runs
		op_idle = (r.state == NVAC_IDLE);
		// both triggers in one write start nothing
		both_trig = wr_pt & wr_ft;
		// enables must stand before the trigger write
		pt_allowed = r.program_enable;
		ft_allowed = r.fetch_enable;
	end

	// ----------------------------------------
	// trigger qualification
	// ----------------------------------------
	always_comb begin
		want_write = 1'b0;
		want_read = 1'b0;
		if (ctrl_wr && op_idle && !both_trig) begin
			want_write = wr_pt & pt_allowed;
			want_read = wr_ft & ft_allowed;
		end
	end

	// ----------------------------------------
	// write start
	// ----------------------------------------
	assign start_write = want_write;

	// ----------------------------------------
	// write timer
	// ----------------------------------------
	nvac_write_timer u_timer (
		.i_clk(i_clk),
		.i_srst(i_srst),
		.i_start(start_write),
		.i_slow_clk(i_slow_clk),
		.o_busy(timer_busy),
		.o_done(write_done)
	);

	assign commit = (r.state == NVAC_WRITE) & write_done;

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		next_r = r;
		next_r.gie_clear = 1'b0;

		// register reads answer one cycle later
		if (i_bus_rd) begin
			next_r.rdata = read_view;
		end

		// software writes
		if (i_bus_wr) begin
			if (hit_addr) begin
				next_r.addr = i_bus_wdata[`NVAC_AW-1:0];
			end else if (hit_data) begin
				next_r.data = i_bus_wdata;
			end else if (hit_bank) begin
				next_r.bank_select_bit = i_bus_wdata[`NVAC_BANK_BIT];
			end else if (hit_ctrl) begin
				next_r.program_enable = wr_pe;
				next_r.fetch_enable = wr_fe;
			end
		end

		// operation launch
		if (want_write) begin
			next_r.program_trigger = 1'b1;
			next_r.state = NVAC_WRITE;
		end else if (want_read) begin
			next_r.fetch_trigger = 1'b1;
			next_r.rd_cnt = '0;
			next_r.state = NVAC_READ;
		end

		// serviced interrupt clears flag and global enable
		// auto clear on service
		if (svc_hit) begin
			next_r.nv_irq_flag = 1'b0;
			next_r.gie_clear = 1'b1;
		end

		case (r.state)
			NVAC_IDLE: begin
				next_r.rd_cnt = '0;
			end
			NVAC_READ: begin
				if (read_last) begin
					next_r.data = store_rdata;
					next_r.fetch_trigger = 1'b0;
					next_r.state = NVAC_IDLE;
				end else begin
					next_r.rd_cnt = r.rd_cnt + 2'h1;
				end
			end
			NVAC_WRITE: begin
				if (commit) begin
					next_r.program_trigger = 1'b0;
					next_r.nv_irq_flag = 1'b1;
					next_r.state = NVAC_IDLE;
				end
			end
			default: begin
				next_r.state = NVAC_IDLE;
			end
		endcase
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	// ----------------------------------------
	// store port
	// ----------------------------------------
	// 32 by 8 store, no reset
	always_ff @(posedge i_clk) begin
		if (commit) begin
			store[r.addr] <= r.data;
		end
	end

	// byte taken by a finishing read
	assign store_rdata = store[r.addr];

	// ----------------------------------------
	// read cycle end
	// ----------------------------------------
	// read done in few cycles
	assign read_last = (r.state == NVAC_READ) && (r.rd_cnt == `NVAC_READ_CYCLES - 2'h1);

	// ----------------------------------------
	// service handshake
	// ----------------------------------------
	// service only counts with flag set
	assign svc_hit = i_irq_serviced & r.nv_irq_flag;

	// ----------------------------------------
	// interrupt gating
	// ----------------------------------------
	assign irq_gate = i_nv_irq_enable & i_global_irq_enable & ~i_stack_full;

	// ----------------------------------------
	// operation status
	// ----------------------------------------
	assign op_active = (r.state != NVAC_IDLE);

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	// read data held until next bus read
	assign o_bus_rdata = r.rdata;
	assign o_nv_irq_flag = r.nv_irq_flag;
	assign o_irq_request = r.nv_irq_flag & irq_gate;
	assign o_global_irq_clear = r.gie_clear;
	assign o_busy = op_active | timer_busy;

endmodule : nvac_top

//--- testbench/nvac_assertions.sv
// port checker of the store access block
`timescale 1ns/1ps
`include "nvac_params.svh"
module nvac_checker
	import nvac_pkg::*;
(
	// clock and reset
	input wire logic i_clk,
	input wire logic i_srst,
	// bus
	input wire logic i_bus_wr,
	input wire logic i_bus_rd,
	input wire logic [`NVAC_DW-1:0] o_bus_rdata,
	// interrupt side
	input wire logic i_nv_irq_enable,
	input wire logic i_global_irq_enable,
	input wire logic i_stack_full,
	input wire logic i_irq_serviced,
	input wire logic o_nv_irq_flag,
	input wire logic o_irq_request,
	input wire logic o_global_irq_clear,
	input wire logic o_busy
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_srst);
	sequence op_min;
		o_busy [*2];
	endsequence
	sequence op_end;
		##[0:1000] !o_busy;
	endsequence
	rst_clear_a: assert property ($fell(i_srst) |-> !o_busy && !o_nv_irq_flag && o_bus_rdata == 8'h00)
		else $error("state not cleared by reset");
	irq_gate_a: assert property (o_irq_request == (o_nv_irq_flag && i_nv_irq_enable
		&& i_global_irq_enable && !i_stack_full)) else $error("request gating wrong");
	service_clear_a: assert property (o_nv_irq_flag && i_irq_serviced && !o_busy
		|=> !o_nv_irq_flag && o_global_irq_clear) else $error("service did not clear flag");
	clear_cause_a: assert property (o_global_irq_clear |-> $past(i_irq_serviced) && $past(o_nv_irq_flag))
		else $error("enable clear without service");
	flag_on_end_a: assert property ($rose(o_nv_irq_flag) |-> $fell(o_busy))
		else $error("flag set outside operation end");
	flag_hold_a: assert property ($fell(o_nv_irq_flag) |-> $past(i_irq_serviced) || $past(i_srst))
		else $error("flag dropped without service");
	busy_span_a: assert property ($rose(o_busy) |-> op_min ##1 op_end)
		else $error("operation length out of range");
	start_by_write_a: assert property ($rose(o_busy) |-> $past(i_bus_wr))
		else $error("operation began without a write");
	rdata_hold_a: assert property ($changed(o_bus_rdata) |-> $past(i_bus_rd) || $past(i_srst))
		else $error("read data changed without a read");
endmodule : nvac_checker

bind nvac_top nvac_checker u_chk (.i_clk(i_clk), .i_srst(i_srst), .i_bus_wr(i_bus_wr),
	.i_bus_rd(i_bus_rd), .o_bus_rdata(o_bus_rdata), .i_nv_irq_enable(i_nv_irq_enable),
	.i_global_irq_enable(i_global_irq_enable), .i_stack_full(i_stack_full),
	.i_irq_serviced(i_irq_serviced), .o_nv_irq_flag(o_nv_irq_flag), .o_irq_request(o_irq_request),
	.o_global_irq_clear(o_global_irq_clear), .o_busy(o_busy));

//--- testbench/tb.sv
// self-checking bench of the store access block
`timescale 1ns/1ps
`include "nvac_params.svh"
module tb;
	import nvac_pkg::*;
	logic i_clk = 1'b0;
	logic i_srst = 1'b1;
	logic [7:0] a = 8'h00, d = 8'h00, q, md;
	logic ind = 1'b0, wr = 1'b0, rd = 1'b0, slow = 1'b0, en = 1'b0, gie = 1'b0, sf = 1'b0, svc = 1'b0;
	logic gmask = 1'b0;
	logic [1:0] sc = 2'h0;
	logic [4:0] ma;
	wire logic [7:0] rdata;
	wire logic flag, req, gclr, busy;
	integer seed = 32293, fails = 0, n_compared = 0, i, k;

	nvac_top DUT (.i_clk(i_clk), .i_srst(i_srst), .i_bus_addr(a), .i_bus_indirect(ind), .i_bus_wr(wr),
		.i_bus_rd(rd), .i_bus_wdata(d), .o_bus_rdata(rdata), .i_slow_clk(slow), .i_nv_irq_enable(en),
		.i_global_irq_enable(gie), .i_stack_full(sf), .i_irq_serviced(svc), .o_nv_irq_flag(flag),
		.o_irq_request(req), .o_global_irq_clear(gclr), .o_busy(busy));

	initial begin
		forever #50 i_clk = ~i_clk;
	end

	// slow pacing clock and random interrupt gating
	always @(posedge i_clk) begin
		sc <= sc + 2'h1;
		slow <= sc[1];
		// global enable held low around write start
		{en, gie, sf} <= 3'($random(seed)) & {1'b1, ~gmask, 1'b1};
	end

	function automatic logic [7:0] addr_exp(input logic [7:0] v);
		return {3'h0, v[4:0]};
	endfunction : addr_exp

	task chk(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task acc(input logic w, input logic in, input logic [7:0] ad, input logic [7:0] dv);
		@(posedge i_clk);
		wr <= w;
		rd <= ~w;
		ind <= in;
		a <= ad;
		d <= dv;
		@(posedge i_clk);
		wr <= 1'b0;
		rd <= 1'b0;
		@(posedge i_clk);
		#1 q = rdata;
	endtask : acc

	task poll(input integer b);
		k = 0;
		do begin
			acc(1'b0, 1'b1, `NVAC_CTRL_OFS, 8'h00);
			k++;
		end while (q[b] !== 1'b0 && k < 300);
		chk({7'h00, q[b]}, 8'h00);
	endtask : poll

	task finish_test;
		$display("compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : finish_test

	initial begin
		#(20000 * 100);
		fails++;
		finish_test;
	end

	initial begin
		repeat (12) @(posedge i_clk);
		i_srst <= 1'b0;
		acc(1'b0, 1'b0, `NVAC_ADDR_OFS, 8'h00); chk(q, 8'h00);
		acc(1'b0, 1'b0, `NVAC_DATA_OFS, 8'h00); chk(q, 8'h00);
		acc(1'b0, 1'b1, `NVAC_CTRL_OFS, 8'h00); chk(q, 8'h00);
		acc(1'b1, 1'b0, `NVAC_BANKSEL_OFS, 8'hff);
		acc(1'b0, 1'b0, `NVAC_BANKSEL_OFS, 8'h00); chk(q, 8'h01);
		acc(1'b1, 1'b0, `NVAC_ADDR_OFS, 8'hff);
		acc(1'b0, 1'b0, `NVAC_ADDR_OFS, 8'h00); chk(q, addr_exp(8'hff));
		acc(1'b1, 1'b0, `NVAC_CTRL_OFS, 8'h0a);
		acc(1'b0, 1'b0, `NVAC_CTRL_OFS, 8'h00); chk(q, 8'h00);
		acc(1'b0, 1'b1, `NVAC_CTRL_OFS, 8'h00); chk(q, 8'h00);
		acc(1'b1, 1'b1, `NVAC_CTRL_OFS, 8'h04);
		acc(1'b0, 1'b1, `NVAC_CTRL_OFS, 8'h00); chk(q, 8'h00);
		acc(1'b1, 1'b1, `NVAC_CTRL_OFS, 8'h01);
		acc(1'b0, 1'b1, `NVAC_CTRL_OFS, 8'h00); chk(q, 8'h00);
		acc(1'b1, 1'b1, `NVAC_CTRL_OFS, 8'hfa);
		acc(1'b1, 1'b1, `NVAC_CTRL_OFS, 8'h0f);
		acc(1'b0, 1'b1, `NVAC_CTRL_OFS, 8'h00); chk(q, 8'h0a);
		chk({7'h00, busy}, 8'h00);
		// write then read back, ends of the range first
		for (i = 0; i < 6; i++) begin
			ma = (i < 2) ? 5'(i * 31) : 5'($random(seed));
			md = 8'($random(seed));
			acc(1'b1, 1'b0, `NVAC_ADDR_OFS, {3'h0, ma});
			acc(1'b1, 1'b0, `NVAC_DATA_OFS, md);
			gmask <= 1'b1;
			acc(1'b1, 1'b1, `NVAC_CTRL_OFS, 8'h08);
			acc(1'b1, 1'b1, `NVAC_CTRL_OFS, 8'h0c);
			gmask <= 1'b0;
			chk({7'h00, busy}, 8'h01);
			poll(2);
			chk({7'h00, flag}, 8'h01);
			chk({7'h00, req}, {7'h00, en & gie & ~sf});
			@(posedge i_clk);
			svc <= 1'b1;
			@(posedge i_clk);
			svc <= 1'b0;
			#1 chk({6'h00, flag, gclr}, 8'h01);
			acc(1'b1, 1'b0, `NVAC_DATA_OFS, ~md);
			acc(1'b1, 1'b1, `NVAC_CTRL_OFS, 8'h02);
			acc(1'b1, 1'b1, `NVAC_CTRL_OFS, 8'h03);
			poll(0);
			acc(1'b0, 1'b0, `NVAC_DATA_OFS, 8'h00); chk(q, md);
			acc(1'b1, 1'b0, `NVAC_ADDR_OFS, 8'h00);
			acc(1'b0, 1'b0, `NVAC_DATA_OFS, 8'h00); chk(q, md);
		end
		// reset with program enable set, no operation running
		acc(1'b1, 1'b1, `NVAC_CTRL_OFS, 8'h08);
		@(posedge i_clk);
		i_srst <= 1'b1;
		@(posedge i_clk);
		i_srst <= 1'b0;
		acc(1'b0, 1'b0, `NVAC_BANKSEL_OFS, 8'h00); chk(q, 8'h00);
		acc(1'b1, 1'b0, `NVAC_BANKSEL_OFS, 8'h01);
		acc(1'b0, 1'b1, `NVAC_CTRL_OFS, 8'h00); chk(q, 8'h00);
		finish_test;
	end
endmodule : tb
